// ==== swc_handler.sv ====
/*
 * stream write command handler: shadow registers, sector sequencing,
 * completion time limit, flush and ending status.
 * assumes link logic and media path run on CLK and obey the handshakes.
 */
`timescale 1ns/1ps
`default_nettype none
module swc_handler #(
   parameter logic [39:0] MIN_LIMIT_US = 40'h00000003e8
) (
   input  wire logic        CLK,
   input  wire logic        NRST,
   input  wire logic        WR_STB,
   input  wire logic [2:0]  WR_ADDR,
   input  wire logic [7:0]  WR_DATA,
   input  wire logic        CFG_WE,
   input  wire logic [2:0]  CFG_STREAM,
   input  wire logic [7:0]  CFG_LIMIT,
   input  wire logic [31:0] TIME_UNIT_US,
   input  wire logic        SECT_DONE,
   input  wire logic        SECT_ERR,
   input  wire logic        SECT_IDNF,
   input  wire logic        FLUSH_DONE,
   output var  logic [7:0]  STATUS,
   output var  logic [7:0]  ERROR,
   output var  logic [47:0] FAIL_LBA,
   output var  logic        INTRQ,
   output var  logic        SECT_REQ,
   output var  logic [47:0] SECT_LBA,
   output var  logic        FLUSH_REQ,
   output var  logic [2:0]  STREAM_ID,
   output var  logic        URGENT,
   output var  logic        RESUME,
   output var  logic        LOG_TMO,
   output var  logic        LOG_IDNF,
   output var  logic        LOG_ABRT
);
   ////////////////////////////////////////////////////////////////////////////////
   swc_pkg::swc_feat_s    feat_cur_r;
   logic [7:0]            feat_prev_r;
   logic [7:0]            cnt_cur_r;
   logic [7:0]            cnt_prev_r;
   logic [47:0]           lba_r;
   swc_pkg::swc_state_e   state_r;
   swc_pkg::swc_feat_s    opt_r;
   logic [16:0]           remain_r;
   logic [4:0]            presc_r;
   logic [39:0]           elapsed_r;
   logic [39:0]           limit_r;
   logic                  limit_on_r;
   logic                  tmo_r;
   logic                  hard_r;
   logic                  soft_r;
   logic                  idnf_r;
   logic                  mem_valid;
   logic [7:0]            mem_limit;
   logic                  start;
   logic                  timeout;
   logic [7:0]            lim_src;
   logic [39:0]           lim_prod;
   swc_pkg::swc_status_s  status_r;
   swc_pkg::swc_error_s   error_r;

   assign STATUS = status_r;
   assign ERROR  = error_r;

   // writes are refused while busy so a running command keeps its parameters
   assign start   = WR_STB && (WR_ADDR == swc_pkg::REG_COMMAND) &&
                    (WR_DATA == swc_pkg::CMD_STREAM_WRITE) &&
                    (state_r == swc_pkg::ST_IDLE);
   assign timeout = limit_on_r && (elapsed_r >= limit_r) &&
                    ((state_r == swc_pkg::ST_XFER) || (state_r == swc_pkg::ST_FLUSH));

   ////////////////////////////////////////////////////////////////////////////////
   // shadow registers: each write pushes the current byte into previous
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         feat_cur_r  <= '0;
         feat_prev_r <= 8'h00;
         cnt_cur_r   <= 8'h00;
         cnt_prev_r  <= 8'h00;
         lba_r       <= 48'h000000000000;
      end else if (WR_STB && (state_r == swc_pkg::ST_IDLE)) begin
         unique case (WR_ADDR)
            swc_pkg::REG_FEATURE: begin
               feat_prev_r <= feat_cur_r;
               feat_cur_r  <= WR_DATA;
            end
            swc_pkg::REG_COUNT: begin
               cnt_prev_r <= cnt_cur_r;
               cnt_cur_r  <= WR_DATA;
            end
            swc_pkg::REG_LBA_LO: begin
               lba_r[31:24] <= lba_r[7:0];
               lba_r[7:0]   <= WR_DATA;
            end
            swc_pkg::REG_LBA_MID: begin
               lba_r[39:32] <= lba_r[15:8];
               lba_r[15:8]  <= WR_DATA;
            end
            swc_pkg::REG_LBA_HI: begin
               lba_r[47:40] <= lba_r[23:16];
               lba_r[23:16] <= WR_DATA;
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   swc_stream_mem swc_stream_mem_inst (
      .clk        (CLK),
      .nrst       (NRST),
      .wr_en      (CFG_WE),
      .wr_addr    (CFG_STREAM),
      .wr_limit   (CFG_LIMIT),
      .rd_addr    (feat_cur_r.stream),
      .rd_valid_r (mem_valid),
      .rd_limit_r (mem_limit)
   );

   // multiplier byte zero falls back to the stream default, else no limit
   assign lim_src  = (feat_prev_r != 8'h00) ? feat_prev_r :
                     (mem_valid ? mem_limit : 8'h00);
   assign lim_prod = 40'(lim_src) * 40'(TIME_UNIT_US);

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         state_r <= swc_pkg::ST_IDLE;
      end else begin
         unique case (state_r)
            swc_pkg::ST_IDLE:   if (start) state_r <= swc_pkg::ST_LOOKUP;
            swc_pkg::ST_LOOKUP: state_r <= swc_pkg::ST_XFER;
            swc_pkg::ST_XFER: begin
               if (timeout) begin
                  state_r <= swc_pkg::ST_END;
               end else if (SECT_DONE && SECT_ERR && !opt_r.cwm) begin
                  state_r <= swc_pkg::ST_END;
               end else if (SECT_DONE && (remain_r == 17'h00001)) begin
                  // errors under continuous write do not cut the run short
                  state_r <= opt_r.flush ? swc_pkg::ST_FLUSH
                                         : swc_pkg::ST_END;
               end
            end
            swc_pkg::ST_FLUSH: begin
               if (timeout || FLUSH_DONE) state_r <= swc_pkg::ST_END;
            end
            swc_pkg::ST_END:    state_r <= swc_pkg::ST_IDLE;
         endcase
      end
   end

   // command options latched at the command write
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         opt_r     <= '0;
         STREAM_ID <= 3'h0;
         URGENT    <= 1'b0;
         RESUME    <= 1'b0;
      end else if (start) begin
         opt_r     <= feat_cur_r;
         STREAM_ID <= feat_cur_r.stream;
         URGENT    <= feat_cur_r.prio;
         RESUME    <= feat_cur_r.resume;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sector sequencing; the media path sees urgency and resume as levels
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         remain_r <= 17'h00000;
         SECT_LBA <= 48'h000000000000;
         SECT_REQ <= 1'b0;
      end else if (start) begin
         remain_r <= ({cnt_prev_r, cnt_cur_r} == 16'h0000) ? swc_pkg::MAX_SECTORS
                     : {1'b0, cnt_prev_r, cnt_cur_r};
         SECT_LBA <= lba_r;
      end else if (state_r == swc_pkg::ST_LOOKUP) begin
         SECT_REQ <= 1'b1;
      end else if (state_r == swc_pkg::ST_XFER) begin
         if (SECT_DONE) begin
            remain_r <= remain_r - 17'h00001;
            SECT_LBA <= SECT_LBA + 48'h000000000001;
         end
         if (timeout || (SECT_DONE && ((SECT_ERR && !opt_r.cwm) ||
                                       (remain_r == 17'h00001)))) begin
            SECT_REQ <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         FLUSH_REQ <= 1'b0;
      end else begin
         FLUSH_REQ <= (state_r == swc_pkg::ST_FLUSH) && !FLUSH_DONE && !timeout;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // completion timer, started by the command write itself
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         limit_r    <= 40'h0000000000;
         limit_on_r <= 1'b0;
      end else if (state_r == swc_pkg::ST_LOOKUP) begin
         limit_on_r <= (lim_src != 8'h00);
         limit_r    <= (lim_prod < MIN_LIMIT_US) ? MIN_LIMIT_US : lim_prod;
      end else if (state_r == swc_pkg::ST_END) begin
         limit_on_r <= 1'b0;
      end
   end

   // the timer idles at zero outside commands to save toggling
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         presc_r   <= 5'h00;
         elapsed_r <= 40'h0000000000;
      end else if ((state_r == swc_pkg::ST_IDLE) || (state_r == swc_pkg::ST_END) ||
                   ((state_r != swc_pkg::ST_LOOKUP) && !limit_on_r)) begin
         presc_r   <= 5'h00;
         elapsed_r <= 40'h0000000000;
      end else if (presc_r == 5'(swc_pkg::CYC_PER_US - 1)) begin
         presc_r   <= 5'h00;
         elapsed_r <= elapsed_r + 40'h0000000001;
      end else begin
         presc_r <= presc_r + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // end causes; an error and a timeout in one cycle both count
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         tmo_r    <= 1'b0;
         hard_r   <= 1'b0;
         soft_r   <= 1'b0;
         idnf_r   <= 1'b0;
         FAIL_LBA <= 48'h000000000000;
      end else if (start) begin
         tmo_r  <= 1'b0;
         hard_r <= 1'b0;
         soft_r <= 1'b0;
         idnf_r <= 1'b0;
      end else begin
         if (timeout) tmo_r <= 1'b1;
         if ((state_r == swc_pkg::ST_XFER) && SECT_DONE && SECT_ERR) begin
            if (opt_r.cwm) soft_r <= 1'b1;
            else hard_r <= 1'b1;
            if (!soft_r) begin
               FAIL_LBA <= SECT_LBA;
               idnf_r   <= SECT_IDNF;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // ending status, completion interrupt and error log flags
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         status_r <= swc_pkg::STATUS_RST;
         error_r  <= swc_pkg::ERROR_RST;
         INTRQ    <= 1'b0;
         LOG_TMO  <= 1'b0;
         LOG_IDNF <= 1'b0;
         LOG_ABRT <= 1'b0;
      end else if (start) begin
         status_r     <= swc_pkg::STATUS_RST;
         status_r.bsy <= 1'b1;
         error_r      <= swc_pkg::ERROR_RST;
         INTRQ        <= 1'b0;
         LOG_TMO      <= 1'b0;
         LOG_IDNF     <= 1'b0;
         LOG_ABRT     <= 1'b0;
      end else if (state_r == swc_pkg::ST_END) begin
         INTRQ        <= 1'b1;
         status_r.bsy <= 1'b0;
         status_r.strm_err <= opt_r.cwm && (tmo_r || soft_r);
         status_r.err <= !opt_r.cwm && (tmo_r || hard_r);
         error_r.tmo  <= tmo_r;
         error_r.idnf <= (hard_r || soft_r) && idnf_r;
         error_r.abrt <= ((hard_r || soft_r) && !idnf_r) || (tmo_r && !opt_r.cwm);
         LOG_TMO      <= tmo_r;
         LOG_IDNF     <= (hard_r || soft_r) && idnf_r;
         LOG_ABRT     <= (hard_r || soft_r) && !idnf_r;
      end else begin
         INTRQ <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   a_cmd_busy: assert property (@(posedge CLK) disable iff (!NRST)
      start |=> (status_r.bsy && state_r == swc_pkg::ST_LOOKUP))
      else $error("command write did not set busy");

   a_zero_count: assert property (@(posedge CLK) disable iff (!NRST)
      (start && {cnt_prev_r, cnt_cur_r} == 16'h0000) |=> (remain_r == 17'h10000))
      else $error("zero count not taken as 65536");

   a_stream_sel: assert property (@(posedge CLK) disable iff (!NRST)
      start |=> (STREAM_ID == $past(feat_cur_r.stream)))
      else $error("stream select not latched");

   a_min_limit: assert property (@(posedge CLK) disable iff (!NRST)
      limit_on_r |-> (limit_r >= MIN_LIMIT_US))
      else $error("limit below minimum");

   a_tmo_stop: assert property (@(posedge CLK) disable iff (!NRST)
      timeout |=> (state_r == swc_pkg::ST_END) ##1 (INTRQ && error_r.tmo && !status_r.bsy))
      else $error("timeout did not end command");

   a_cwm_noerr: assert property (@(posedge CLK) disable iff (!NRST)
      (state_r == swc_pkg::ST_END && opt_r.cwm) |=> (!status_r.err && INTRQ))
      else $error("error bit set in continuous write");

   a_cwm_errs: assert property (@(posedge CLK) disable iff (!NRST)
      (state_r == swc_pkg::ST_XFER && opt_r.cwm && SECT_DONE && SECT_ERR &&
       remain_r > 17'h00001 && !timeout) |=> (state_r == swc_pkg::ST_XFER && SECT_REQ))
      else $error("continuous write stopped on error");

   a_hard_stop: assert property (@(posedge CLK) disable iff (!NRST)
      (state_r == swc_pkg::ST_XFER && !opt_r.cwm && SECT_DONE && SECT_ERR) |=>
      !SECT_REQ ##1 (status_r.err && FAIL_LBA == $past(SECT_LBA, 2)))
      else $error("error without continuous write not reported");

   a_flush_first: assert property (@(posedge CLK) disable iff (!NRST)
      (state_r == swc_pkg::ST_FLUSH && !FLUSH_DONE && !timeout) |=>
      (state_r == swc_pkg::ST_FLUSH && FLUSH_REQ && !INTRQ))
      else $error("completion before flush");

   a_timer_off: assert property (@(posedge CLK) disable iff (!NRST)
      (state_r == swc_pkg::ST_IDLE) |-> (elapsed_r == 40'h0000000000 && !limit_on_r))
      else $error("timer running while idle");
endmodule // swc_handler
`default_nettype wire

// ==== swc_pkg.sv ====
/*
 * constants, types and the register map of the stream write command handler.
 * assumes the link logic and the media path share the handler's clock.
 */
// Summary of operation
// - priority bit set: finish as fast as possible, always within the time limit.
// - continuous write bit set: never abort on transfer or media errors.
// - continuous write with errors: move all sectors, end with stream error, log type.
// - continuous write and limit expired: stop, clear busy and error, log timeout.
// - always try to move the whole requested amount within the limit.
// - flush bit set: commit stream data to media before reporting completion; skipped when a timeout or a hard error ends the command.
// - resume bit set: host starts at last error, recovery may continue.
// - low three feature bits select the stream whose settings apply.
// - limit equals previous feature byte times the identify time unit, in microseconds.
// - previous feature byte zero: use the stream's configured default limit.
// - default zero or stream never configured: no time limit at all.
// - time counts from the command write to the final completion interrupt.
// - a limit below the device minimum is raised to that minimum.
// - a count of zero means 65536 sectors.
// - the command code is 3Bh, written to the command register.
// - unrecoverable error returns the 48-bit address of the first failing sector.
`default_nettype none
package swc_pkg;
   localparam logic [7:0] CMD_STREAM_WRITE = 8'h3b;
   localparam logic [2:0] REG_FEATURE      = 3'h1;
   localparam logic [2:0] REG_COUNT        = 3'h2;
   localparam logic [2:0] REG_LBA_LO       = 3'h3;
   localparam logic [2:0] REG_LBA_MID      = 3'h4;
   localparam logic [2:0] REG_LBA_HI       = 3'h5;
   localparam logic [2:0] REG_COMMAND      = 3'h7;
   localparam int         STREAMS          = 8;
   localparam int         STREAM_W         = 3;
   localparam int         CNT_W            = 17;
   localparam logic [16:0] MAX_SECTORS     = 17'h10000;
   localparam int         CLK_PERIOD_NS    = 40;
   localparam int         NS_PER_US        = 1000;
   localparam int         CYC_PER_US       = NS_PER_US / CLK_PERIOD_NS;
   localparam logic [7:0] STATUS_RST       = 8'h40;
   localparam logic [7:0] ERROR_RST        = 8'h00;

   typedef struct packed {
      logic                prio;
      logic                cwm;
      logic                flush;
      logic                resume;
      logic                unused;
      logic [STREAM_W-1:0] stream;
   } swc_feat_s;

   typedef struct packed {
      logic bsy;
      logic rdy;
      logic strm_err;
      logic dwe;
      logic drq;
      logic cor;
      logic idx;
      logic err;
   } swc_status_s;

   typedef struct packed {
      logic crc;
      logic unc;
      logic z5;
      logic idnf;
      logic z3;
      logic abrt;
      logic z1;
      logic tmo;
   } swc_error_s;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_LOOKUP = 3'h1,
      ST_XFER   = 3'h3,
      ST_FLUSH  = 3'h2,
      ST_END    = 3'h6
   } swc_state_e;
endpackage
`default_nettype wire

// ==== swc_stream_mem.sv ====
/*
 * per-stream default time limit table, written by stream configuration.
 * assumes one write port and a read address held steady by the caller.
 */
`timescale 1ns/1ps
`default_nettype none
module swc_stream_mem (
   input  wire logic                          clk,
   input  wire logic                          nrst,
   input  wire logic                          wr_en,
   input  wire logic [swc_pkg::STREAM_W-1:0]  wr_addr,
   input  wire logic [7:0]                    wr_limit,
   input  wire logic [swc_pkg::STREAM_W-1:0]  rd_addr,
   output var  logic                          rd_valid_r,
   output var  logic [7:0]                    rd_limit_r
);
   logic [8:0] mem_r [swc_pkg::STREAMS];

   // valid bits must clear at reset, so the table is flops, not a ram macro
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < swc_pkg::STREAMS; i++) begin
            mem_r[i] <= 9'h000;
         end
      end else if (wr_en) begin
         mem_r[wr_addr] <= {1'b1, wr_limit};
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_valid_r <= 1'b0;
         rd_limit_r <= 8'h00;
      end else begin
         rd_valid_r <= mem_r[rd_addr][8];
         rd_limit_r <= mem_r[rd_addr][7:0];
      end
   end
endmodule // swc_stream_mem
`default_nettype wire

// ==== swc_media_model.sv ====
/* media path model for the stream write handler: answers sector and flush requests.
   assumes the handler runs on the same clock and reset. */
`timescale 1ns/1ps
`default_nettype none
module swc_media_model #(
   parameter int FLUSH_LAT = 5
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        sect_req,
   input  wire logic        flush_req,
   input  wire logic        stall,
   input  wire logic        slow,
   input  wire logic        idnf,
   input  wire logic [16:0] err_at,
   output var  logic        sect_done,
   output var  logic        sect_err,
   output var  logic        sect_idnf,
   output var  logic        flush_done,
   output var  logic [16:0] nsect
);
   logic        req_q;
   logic        go;
   logic [16:0] nxt;
   logic [3:0]  fc;
   ////////////////////////////////////////////////////////////////////////////////
   // slow mode answers every other cycle; stall never answers
   assign go  = sect_req & ~stall & (~slow | ~sect_done);
   assign nxt = (sect_req & ~req_q) ? 17'h0 : nsect + {16'h0, sect_req & sect_done};
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         req_q      <= 1'b0;
         nsect      <= 17'h0;
         sect_done  <= 1'b0;
         sect_err   <= 1'b0;
         sect_idnf  <= 1'b0;
         fc         <= 4'h0;
         flush_done <= 1'b0;
      end else begin
         req_q      <= sect_req;
         nsect      <= sect_req ? nxt : nsect;
         sect_done  <= go;
         // qualifiers flip while idle so a stale value is never mistaken for an answer
         sect_err   <= go ? (nxt >= err_at) : ~sect_err;
         sect_idnf  <= go ? idnf : ~sect_idnf;
         fc         <= flush_req ? fc + 4'h1 : 4'h0;
         flush_done <= flush_req && (fc == 4'(FLUSH_LAT - 1));
      end
   end
endmodule // swc_media_model
`default_nettype wire

// ==== swc_handler_tb.sv ====
/* self-checking bench for the stream write handler with a media model.
   assumes the handler's timer counts 25 cycles per microsecond. */
`timescale 1ns/1ps
`default_nettype none
module swc_handler_tb;
   typedef struct {
      logic [7:0] st; logic [10:0] er; logic [10:0] em; logic [16:0] ns;
      logic [47:0] fl; logic fls; logic [4:0] sid; int tmin; int tmax;
   } swc_note_s;
   logic        CLK, NRST, WR_STB, CFG_WE, SECT_DONE, SECT_ERR, SECT_IDNF, FLUSH_DONE;
   logic [2:0]  WR_ADDR, CFG_STREAM, STREAM_ID, s;
   logic [7:0]  WR_DATA, CFG_LIMIT, STATUS, ERROR, cur;
   logic [31:0] TIME_UNIT_US, r;
   logic [47:0] FAIL_LBA, SECT_LBA, l;
   logic        INTRQ, SECT_REQ, FLUSH_REQ, URGENT, RESUME, LOG_TMO, LOG_IDNF, LOG_ABRT;
   logic        stall, slow, idnf, bsy_q, fls;
   logic [16:0] err_at, nsect;
   logic [15:0] c;
   swc_note_s   q[$];
   swc_note_s   n;
   int          n_mismatch, checks_done, cyc, t0, k;
   ////////////////////////////////////////////////////////////////////////////////
   swc_handler #(.MIN_LIMIT_US(40'h0000000002)) swc_handler_inst (.CLK(CLK), .NRST(NRST),
      .WR_STB(WR_STB), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .CFG_WE(CFG_WE),
      .CFG_STREAM(CFG_STREAM), .CFG_LIMIT(CFG_LIMIT), .TIME_UNIT_US(TIME_UNIT_US),
      .SECT_DONE(SECT_DONE), .SECT_ERR(SECT_ERR), .SECT_IDNF(SECT_IDNF),
      .FLUSH_DONE(FLUSH_DONE), .STATUS(STATUS), .ERROR(ERROR), .FAIL_LBA(FAIL_LBA),
      .INTRQ(INTRQ), .SECT_REQ(SECT_REQ), .SECT_LBA(SECT_LBA), .FLUSH_REQ(FLUSH_REQ),
      .STREAM_ID(STREAM_ID), .URGENT(URGENT), .RESUME(RESUME), .LOG_TMO(LOG_TMO),
      .LOG_IDNF(LOG_IDNF), .LOG_ABRT(LOG_ABRT));
   swc_media_model swc_media_model_inst (.clk(CLK), .nrst(NRST), .sect_req(SECT_REQ),
      .flush_req(FLUSH_REQ), .stall(stall), .slow(slow), .idnf(idnf), .err_at(err_at),
      .sect_done(SECT_DONE), .sect_err(SECT_ERR), .sect_idnf(SECT_IDNF),
      .flush_done(FLUSH_DONE), .nsect(nsect));
   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end
   always @(posedge CLK) cyc <= cyc + 1;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic mism(input string m);
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
   endtask
   task automatic cmp(input logic [47:0] g, input logic [47:0] e, input string m);
      checks_done++;
      if (g !== e) mism(m);
   endtask
   task automatic cmp_t(input int g, input int lo, input int hi);
      checks_done++;
      if (g < lo || g > hi) mism("completion time");
   endtask
   task automatic finish_test;
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   function automatic swc_note_s mk(logic [7:0] st, logic [10:0] er, logic [10:0] em,
      logic [16:0] ns, logic [47:0] fl, logic fls, logic [4:0] sid, int tmin, int tmax);
      mk = '{st, er, em, ns, fl, fls, sid, tmin, tmax};
   endfunction
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      WR_STB  <= 1'b1;
      WR_ADDR <= a;
      WR_DATA <= d;
      @(posedge CLK);
   endtask
   // bounded wait until the note is consumed and the handler is idle again
   task automatic wt(input int lim);
      for (k = 0; k < lim && (q.size() != 0 || STATUS[7] !== 1'b0); k++) @(posedge CLK);
      if (k >= lim) begin
         mism("no completion");
         finish_test();
      end
   endtask
   task automatic cmd(input logic [7:0] pf, input logic [7:0] cf, input logic [15:0] cn,
      input logic [47:0] a, input swc_note_s e);
      q.push_back(e);
      wr(3'h1, pf);
      wr(3'h1, cf);
      wr(3'h2, cn[15:8]);
      wr(3'h2, cn[7:0]);
      wr(3'h3, a[31:24]);
      wr(3'h3, a[7:0]);
      wr(3'h4, a[39:32]);
      wr(3'h4, a[15:8]);
      wr(3'h5, a[47:40]);
      wr(3'h5, a[23:16]);
      wr(3'h7, 8'h3b);
      WR_STB <= 1'b0;
      wt(e.tmax + 20);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(negedge CLK) begin
      if (NRST === 1'b1) begin
         if (STATUS[7] === 1'b1 && bsy_q !== 1'b1) begin
            t0 = cyc;
            fls = 1'b0;
         end
         bsy_q = STATUS[7];
         if (FLUSH_REQ === 1'b1 && FLUSH_DONE === 1'b1) fls = 1'b1;
         if (INTRQ === 1'b1 && q.size() == 0) mism("unexpected interrupt");
         else if (INTRQ === 1'b1) begin
            n = q.pop_front();
            cmp(STATUS, n.st, "ending status");
            cmp({LOG_TMO, LOG_IDNF, LOG_ABRT, ERROR} & n.em, n.er, "error and log");
            if (n.ns !== 17'h1ffff) cmp(nsect, n.ns, "sectors moved");
            if (n.fl !== 48'h0) cmp(FAIL_LBA, n.fl, "failing address");
            cmp(fls, n.fls, "flush before completion");
            cmp({STREAM_ID, URGENT, RESUME}, n.sid, "latched options");
            cmp_t(cyc - t0 + 1, n.tmin, n.tmax);
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      NRST = 1'b0;
      WR_STB = 1'b0;
      WR_ADDR = 3'h0;
      WR_DATA = 8'h00;
      CFG_WE = 1'b0;
      CFG_STREAM = 3'h0;
      CFG_LIMIT = 8'h00;
      TIME_UNIT_US = 32'h1;
      {stall, slow, idnf, bsy_q, fls} = 5'h00;
      err_at = 17'h1ffff;
      n_mismatch = 0;
      checks_done = 0;
      cyc = 0;
      k = $urandom(74);
      repeat (2) @(posedge CLK);
      NRST <= 1'b1;
      @(posedge CLK);
      wr(3'h7, 8'h30);
      WR_STB <= 1'b0;
      repeat (2) @(negedge CLK);
      cmp(STATUS, 8'h40, "foreign code started work");
      @(posedge CLK);
      CFG_WE <= 1'b1;
      CFG_STREAM <= 3'h2;
      CFG_LIMIT <= 8'h03;
      @(posedge CLK);
      CFG_STREAM <= 3'h3;
      CFG_LIMIT <= 8'h00;
      @(posedge CLK);
      CFG_WE <= 1'b0;
      // odd streams only: unconfigured or default zero, so no limit; only the 258-sector first run and slow runs outlast the minimum
      for (int i = 0; i < 4; i++) begin
         r = $urandom();
         l = {r[15:0], $urandom()};
         s = {r[18:17], 1'b1};
         c = (i == 0) ? 16'h0102 : 16'd30 + 16'(r[21:19]);
         slow <= r[22];
         // bit 4 carries the resume request, bit 3 is unused
         cur = {r[23], 2'b00, r[24], 1'b0, s};
         cmd(8'h00, cur, c, l, mk(8'h40, 0, 11'h7ff, {1'b0, c}, 0, 0, {s, r[23], r[24]}, 0,
            2000));
      end
      slow <= 1'b0;
      cmd(8'h00, 8'h01, 16'h0, 48'h5000, mk(8'h40, 0, 11'h7ff, 17'h10000, 0, 0, 5'h04, 0,
         70000));
      err_at <= 17'h2;
      idnf <= 1'b1;
      cmd(8'h00, 8'h01, 16'h5, 48'h1000, mk(8'h41, 11'h210, 11'h7ff, 17'h1ffff, 48'h1002, 0,
         5'h04, 0, 200));
      for (int i = 0; i < 2; i++) begin
         err_at <= 17'h1;
         idnf <= i[0];
         cmd(8'h00, 8'h41, 16'h4, 48'h2000, mk(8'h60, (i == 1) ? 11'h210 : 11'h104, 11'h7ff,
            17'h4, 48'h2001, 0, 5'h04, 0, 200));
      end
      err_at <= 17'h1ffff;
      cmd(8'h00, 8'h31, 16'h2, 48'h2001, mk(8'h40, 0, 11'h7ff, 17'h2, 0, 1, 5'h05, 0,
         200));
      stall <= 1'b1;
      TIME_UNIT_US <= 32'h2;
      cmd(8'h02, 8'h41, 16'h8, 48'h4000, mk(8'h60, 11'h401, 11'h7ff, 17'h0, 0, 0, 5'h04, 100,
         105));
      TIME_UNIT_US <= 32'h1;
      cmd(8'h01, 8'h81, 16'h8, 48'h4000, mk(8'h41, 11'h005, 11'h0ff, 17'h0, 0, 0, 5'h06, 50,
         55));
      cmd(8'h00, 8'h42, 16'h8, 48'h4000, mk(8'h60, 11'h401, 11'h7ff, 17'h0, 0, 0, 5'h08, 75,
         80));
      stall <= 1'b0;
      finish_test();
   end
endmodule // swc_handler_tb
`default_nettype wire
